// *** shared/sasc_pkg.sv ***
// Purpose: Shared constants and types for the converter sequencer control.
// Assumes: 20 MHz system clock, 12-bit successive-approximation core.
// Notes: Channel 8 is the temperature sensor; 0 to 7 are the fixed pins.
package sasc_pkg;
  // ==========================================================================
  // Widths and channel map
  localparam int ADC_BITS = 12;
  localparam int NUM_CH = 8;
  localparam int NBUF = 9;
  localparam int CH_W = 4;
  localparam logic [3:0] TEMP_CH = 4'h8;
  localparam logic [3:0] LAST_PIN_CH = 4'h7;
  localparam int ST_W = 8;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CONV_CLK_MAX_HZ = 14_500_000;
  localparam int CONV_DIV_MIN = (CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
  localparam int CONV_MIN_CLKS = 18;
  localparam int SAMPLE_MIN_CLKS = CONV_MIN_CLKS - ADC_BITS;
  localparam logic [7:0] SAMPLE_MIN = 8'(SAMPLE_MIN_CLKS);
  localparam int RATE_MAX_KSPS = 806;
  // ==========================================================================
  // Buffering and reset values
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 1 + CH_W + ADC_BITS;
  localparam logic [ADC_BITS-1:0] RESULT_RST = 12'h000;
  localparam logic [ADC_BITS-1:0] DAC_MID = 12'h800;
  // ==========================================================================
  // Reference choices
  localparam logic [1:0] REF_VDD = 2'h0;
  localparam logic [1:0] REF_VDD_HALF = 2'h1;
  localparam logic [1:0] REF_INTERNAL = 2'h2;
  localparam logic [1:0] REF_EXTERNAL = 2'h3;
  typedef enum logic [1:0] {CONV_IDLE, CONV_SAMPLE, CONV_SAR} sasc_conv_state_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_FIRMWARE} sasc_seq_state_t;
endpackage : sasc_pkg

// *** shared/sasc_conv_if.sv ***
// Purpose: Carrier between sequencer and conversion engine.
// Assumes: One conversion in flight at a time.
// Notes: ready may be high in the same cycle as done.
`timescale 1ns/1ps
interface sasc_conv_if;
  logic start;
  logic abort;
  logic ready;
  logic done;
  logic [3:0] chan;
  logic [7:0] sample_clks;
  logic [11:0] result;
  logic [3:0] done_chan;
  modport ctrl (output start, abort, chan, sample_clks, input ready, done, result, done_chan);
  modport conv (input start, abort, chan, sample_clks, output ready, done, result, done_chan);
endinterface : sasc_conv_if

// *** hw/sasc_fifo.sv ***
// Purpose: Result FIFO between conversion engine and channel buffers.
// Assumes: Writer respects o_in_ready.
// Notes: Level output lets the writer reserve room ahead.
`timescale 1ns/1ps
module sasc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [LW-1:0] cnt_q;
  logic push, pop;
  assign o_in_ready = cnt_q != LW'(DEPTH);
  assign o_out_valid = cnt_q != '0;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_q[rd_q];
  assign o_level = cnt_q;
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + LW'(push) - LW'(pop);
    end
  end
  // [RL8] No lost results
  a_fifo_no_drop: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_in_valid |-> o_in_ready) // [RL8]
    else $error("result pushed into full fifo");
endmodule : sasc_fifo

// *** hw/sasc_sar_engine.sv ***
// Purpose: Sample-and-hold timing and successive approximation.
// Assumes: i_cmp high when input is at or above the DAC level.
// Notes: Converter clock is the system clock divided by CONV_DIV.
`timescale 1ns/1ps
module sasc_sar_engine import sasc_pkg::*; #(
  parameter int CONV_DIV = CONV_DIV_MIN
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  sasc_conv_if.conv cv,
  input wire logic i_cmp,
  output logic [3:0] o_mux_sel,
  output logic o_sample,
  output logic [11:0] o_dac
);
  localparam int DW = $clog2(CONV_DIV + 1);
  sasc_conv_state_t state_q;
  logic [DW-1:0] div_q;
  logic [7:0] cnt_q;
  logic [3:0] bit_q;
  logic [11:0] sar_q;
  logic tick, accept, last_bit;
  logic [11:0] kept;
  assign tick = div_q == DW'(CONV_DIV - 1);
  assign last_bit = state_q == CONV_SAR && tick && bit_q == 4'h0;
  assign cv.ready = state_q == CONV_IDLE;
  assign accept = cv.start && cv.ready && !cv.abort;
  assign kept = i_cmp ? sar_q : (sar_q & ~(12'h001 << bit_q));
  assign o_sample = state_q == CONV_SAMPLE;
  assign o_dac = sar_q;
  // ==========================================================================
  // Converter clock
  // [RL1] Divided converter clock
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      div_q <= '0;
    end else if (accept || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  // ==========================================================================
  // Conversion sequence
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= CONV_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      sar_q <= RESULT_RST;
      o_mux_sel <= 4'h0;
    end else if (cv.abort) begin
      state_q <= CONV_IDLE;
    end else begin
      case (state_q)
        CONV_IDLE: begin
          // [RL4] [RL9] Programmed aperture
          if (accept) begin
            state_q <= CONV_SAMPLE;
            o_mux_sel <= cv.chan;
            cnt_q <= ((cv.sample_clks < SAMPLE_MIN) ? SAMPLE_MIN : cv.sample_clks) - 8'h01;
          end
        end
        CONV_SAMPLE: begin
          if (tick) begin
            if (cnt_q == 8'h00) begin
              state_q <= CONV_SAR;
              bit_q <= 4'hB;
              sar_q <= DAC_MID;
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
        end
        CONV_SAR: begin
          // [RL2] Twelve bit decisions
          if (tick) begin
            sar_q <= (bit_q == 4'h0) ? kept : (kept | (12'h001 << (bit_q - 4'h1)));
            bit_q <= bit_q - 4'h1;
            if (bit_q == 4'h0) begin
              state_q <= CONV_IDLE;
            end
          end
        end
        default: state_q <= CONV_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cv.done <= 1'b0;
      cv.result <= RESULT_RST;
      cv.done_chan <= 4'h0;
    end else begin
      cv.done <= last_bit && !cv.abort;
      if (last_bit) begin
        cv.result <= kept;
        cv.done_chan <= o_mux_sel;
      end
    end
  end
  // ==========================================================================
  // Checks
  logic [15:0] len_q;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      len_q <= 16'h0000;
    end else if (accept) begin
      len_q <= 16'h0001;
    end else if (len_q != 16'hFFFF) begin
      len_q <= len_q + 16'h0001;
    end
  end
  // [RL1] Minimum conversion length
  a_conv_min_len: assert property (@(posedge i_clock) disable iff (!i_resetn)
    cv.done |-> len_q >= 16'(CONV_MIN_CLKS * CONV_DIV)) // [RL1]
    else $error("conversion shorter than minimum converter clocks");
  c_conv_done: cover property (@(posedge i_clock) disable iff (!i_resetn) cv.done);
endmodule : sasc_sar_engine

// *** hw/sasc_sar_sequencer.sv ***
// Purpose: Channel sequencer, result buffers and range check for the converter.
// Assumes: Control inputs synchronous to i_clock; i_cmp from the analog comparator.
// Notes: Results pass a FIFO; a stalled stream stalls the sequencer.
//
// Contract
// [RL1] Conversion at least eighteen clocks, bounded clock
// [RL2] Twelve-bit results at full aggregate rate
// [RL3] Four reference choices including external pin
// [RL4] Sample aperture length is programmable
// [RL5] Eight-channel sequencer on fixed pins
// [RL6] Scan steps enabled channels without gaps
// [RL7] Hardware scan or firmware channel select
// [RL8] Separate result buffer per channel
// [RL9] Per-channel programmable sample time applied
// [RL10] Low/high limits raise out-of-range interrupt
// [RL11] Range check on each completing result
// [RL12] Temperature sensor is a selectable input
// [RL13] Unavailable in deep-sleep and hibernate
// [RL14] Scan-complete flag after last buffer write
`timescale 1ns/1ps
module sasc_sar_sequencer import sasc_pkg::*; #(
  parameter int CONV_DIV = CONV_DIV_MIN,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_enable,
  input wire logic i_power_ok,
  input wire logic i_scan_mode,
  input wire logic [NUM_CH-1:0] i_chan_en,
  input wire logic [NUM_CH*ST_W-1:0] i_sample_time,
  input wire logic [ST_W-1:0] i_temp_sample_time,
  input wire logic i_fw_start,
  input wire logic [3:0] i_fw_chan,
  input wire logic [1:0] i_ref_sel,
  input wire logic [11:0] i_low_limit,
  input wire logic [11:0] i_high_limit,
  input wire logic i_range_clr,
  input wire logic i_scan_done_clr,
  input wire logic [NBUF-1:0] i_buf_clr,
  input wire logic i_cmp,
  input wire logic i_st_en,
  input wire logic i_st_ready,
  output logic o_st_valid,
  output logic [3:0] o_st_chan,
  output logic [11:0] o_st_data,
  output logic [3:0] o_mux_sel,
  output logic o_temp_sel,
  output logic o_sample,
  output logic [11:0] o_dac,
  output logic [1:0] o_ref_sel,
  output logic o_ext_ref_en,
  output logic o_available,
  output logic o_busy,
  output logic [NBUF*12-1:0] o_results,
  output logic [NBUF-1:0] o_buf_new,
  output logic o_range_irq,
  output logic o_range_low,
  output logic o_range_high,
  output logic o_scan_done
);
  // ==========================================================================
  // Channel helpers
  function automatic logic [3:0] next_enabled(input logic [3:0] cur,
                                              input logic [NUM_CH-1:0] en);
    logic [3:0] r;
    logic [3:0] c;
    r = cur;
    for (int k = NUM_CH; k >= 1; k--) begin
      c = 4'((32'(cur) + k) % NUM_CH);
      if (en[c[2:0]]) begin
        r = c;
      end
    end
    return r;
  endfunction : next_enabled
  function automatic logic [3:0] last_enabled(input logic [NUM_CH-1:0] en);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < NUM_CH; k++) begin
      if (en[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction : last_enabled
  function automatic logic [ST_W-1:0] sample_of(input logic [3:0] ch,
                                                input logic [NUM_CH*ST_W-1:0] st,
                                                input logic [ST_W-1:0] tst);
    logic [ST_W-1:0] r;
    r = tst;
    if (ch < TEMP_CH) begin
      r = st[ch[2:0]*ST_W +: ST_W];
    end
    return r;
  endfunction : sample_of
  // ==========================================================================
  // Declarations
  sasc_conv_if cv ();
  sasc_seq_state_t seq_q;
  logic [3:0] cur_q;
  logic fw_pend_q;
  logic [3:0] fw_chan_q;
  logic fw_ok, run, room, go, scan_req, fw_req;
  logic [3:0] start_chan, scan_next;
  logic inflight_scan_q;
  logic [$clog2(DEPTH+1)-1:0] level;
  logic fifo_out_valid, pop;
  logic [FIFO_W-1:0] fifo_out;
  logic push_last, pop_last;
  logic [3:0] pop_chan;
  logic [11:0] pop_data;
  logic [11:0] buf_q [NBUF];
  logic out_low, out_high;
  // ==========================================================================
  // Sequencer
  // [RL13] Unavailable without the fast clock
  assign run = i_enable && i_power_ok;
  assign fw_ok = i_fw_chan <= TEMP_CH;
  assign room = 32'(level) <= DEPTH - 2;
  assign scan_next = next_enabled(cur_q, i_chan_en);
  assign scan_req = seq_q == SEQ_SCAN && i_chan_en != '0;
  assign fw_req = seq_q == SEQ_FIRMWARE && fw_pend_q;
  // [RL7] Two channel-select methods
  assign start_chan = (seq_q == SEQ_SCAN) ? scan_next : fw_chan_q;
  // [RL6] Start as soon as engine frees
  assign go = run && room && cv.ready && (scan_req || fw_req);
  assign cv.start = go;
  assign cv.abort = !i_power_ok;
  assign cv.chan = start_chan;
  // [RL9] Sample time follows the channel
  assign cv.sample_clks = sample_of(start_chan, i_sample_time, i_temp_sample_time);
  assign o_busy = !cv.ready;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      seq_q <= SEQ_IDLE;
    end else if (!run) begin
      seq_q <= SEQ_IDLE;
    end else begin
      case (seq_q)
        SEQ_IDLE: seq_q <= i_scan_mode ? SEQ_SCAN : SEQ_FIRMWARE;
        SEQ_SCAN: seq_q <= i_scan_mode ? SEQ_SCAN : SEQ_FIRMWARE;
        SEQ_FIRMWARE: seq_q <= i_scan_mode ? SEQ_SCAN : SEQ_FIRMWARE;
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end
  // [RL5] Walk the eight pin channels
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_q <= LAST_PIN_CH;
      inflight_scan_q <= 1'b0;
    end else begin
      if (seq_q != SEQ_SCAN) begin
        cur_q <= LAST_PIN_CH;
      end else if (go) begin
        cur_q <= scan_next;
      end
      if (go) begin
        inflight_scan_q <= seq_q == SEQ_SCAN;
      end
    end
  end
  // [RL12] Temperature sensor as channel eight
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      fw_pend_q <= 1'b0;
      fw_chan_q <= 4'h0;
    end else if (!run) begin
      fw_pend_q <= 1'b0;
    end else if (i_fw_start && fw_ok) begin
      fw_pend_q <= 1'b1;
      fw_chan_q <= i_fw_chan;
    end else if (go && seq_q == SEQ_FIRMWARE) begin
      fw_pend_q <= 1'b0;
    end
  end
  // ==========================================================================
  // Engine and result FIFO
  sasc_sar_engine #(.CONV_DIV(CONV_DIV)) u_engine (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .cv(cv.conv),
    .i_cmp(i_cmp),
    .o_mux_sel(o_mux_sel),
    .o_sample(o_sample),
    .o_dac(o_dac)
  );
  assign o_temp_sel = o_mux_sel == TEMP_CH;
  assign push_last = inflight_scan_q && cv.done_chan == last_enabled(i_chan_en);
  // A stalled stream fills the FIFO and holds the next start
  assign pop = fifo_out_valid && (i_st_ready || !i_st_en);
  assign {pop_last, pop_chan, pop_data} = fifo_out;
  assign o_st_valid = fifo_out_valid && i_st_en;
  assign o_st_chan = pop_chan;
  assign o_st_data = pop_data;
  sasc_fifo #(.WIDTH(FIFO_W), .DEPTH(DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_in_valid(cv.done),
    .o_in_ready(),
    .i_in_data({push_last, cv.done_chan, cv.result}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_out),
    .o_level(level)
  );
  // ==========================================================================
  // Channel buffers
  // [RL8] One buffer per channel
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < NBUF; k++) begin
        buf_q[k] <= RESULT_RST;
      end
    end else if (pop) begin
      buf_q[pop_chan] <= pop_data;
    end
  end
  generate
    for (genvar g = 0; g < NBUF; g++) begin : g_buf
      assign o_results[g*12 +: 12] = buf_q[g];
      // New-result flag: a write beats a clear in the same cycle
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          o_buf_new[g] <= 1'b0;
        end else if (pop && pop_chan == 4'(g)) begin
          o_buf_new[g] <= 1'b1;
        end else if (i_buf_clr[g]) begin
          o_buf_new[g] <= 1'b0;
        end
      end
    end
  endgenerate
  // [RL14] Scan-complete on last buffer write
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_scan_done <= 1'b0;
    end else if (pop && pop_last) begin
      o_scan_done <= 1'b1;
    end else if (i_scan_done_clr) begin
      o_scan_done <= 1'b0;
    end
  end
  // ==========================================================================
  // Range check
  assign out_low = cv.result < i_low_limit;
  assign out_high = cv.result > i_high_limit;
  // [RL10] [RL11] Check each result at completion
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_range_low <= 1'b0;
      o_range_high <= 1'b0;
    end else begin
      if (cv.done && out_low) begin
        o_range_low <= 1'b1;
      end else if (i_range_clr) begin
        o_range_low <= 1'b0;
      end
      if (cv.done && out_high) begin
        o_range_high <= 1'b1;
      end else if (i_range_clr) begin
        o_range_high <= 1'b0;
      end
    end
  end
  assign o_range_irq = o_range_low || o_range_high;
  // ==========================================================================
  // Reference and availability
  // [RL3] Reference selector
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ref_sel <= REF_VDD;
      o_ext_ref_en <= 1'b0;
      o_available <= 1'b0;
    end else begin
      o_ref_sel <= i_ref_sel;
      o_ext_ref_en <= i_ref_sel == REF_EXTERNAL;
      o_available <= i_power_ok;
    end
  end
  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  a_scan_no_gap: assert property (cv.done && run && room && scan_req |-> cv.start) // [RL6]
    else $error("scan left engine idle");
  a_fw_channel: assert property (cv.start && seq_q == SEQ_FIRMWARE |-> ##1 o_mux_sel == $past(fw_chan_q)) // [RL7]
    else $error("firmware channel not applied");
  a_range_irq_set: assert property (cv.done && (out_low || out_high) |=> o_range_irq) // [RL10]
    else $error("out-of-range result not flagged");
  a_range_prompt: assert property (cv.done && out_high && !o_range_high |=> $rose(o_range_high)) // [RL11]
    else $error("range flag not raised at completion");
  a_buf_written: assert property (pop |=> o_buf_new[$past(pop_chan)] && buf_q[$past(pop_chan)] == $past(pop_data)) // [RL8]
    else $error("channel buffer not written");
  a_scan_done_set: assert property (pop && pop_last |=> o_scan_done) // [RL14]
    else $error("scan-complete not set");
  a_scan_done_cause: assert property ($rose(o_scan_done) |-> $past(pop && pop_last)) // [RL14]
    else $error("scan-complete set without last result");
  a_ext_ref: assert property (i_ref_sel == REF_EXTERNAL |=> o_ext_ref_en && o_ref_sel == REF_EXTERNAL) // [RL3]
    else $error("external reference not selected");
  a_power_off: assert property (!i_power_ok |=> !o_sample && !o_busy && !o_available) // [RL13]
    else $error("converter active without fast clock");
  c_scan_done: cover property (pop && pop_last);
  c_range_hit: cover property ($rose(o_range_irq));
  c_stream_stall: cover property (!room && cv.ready && scan_req);
  c_temp_conv: cover property (cv.done && cv.done_chan == TEMP_CH);
endmodule : sasc_sar_sequencer

// *** verification/sasc_analog_model.sv ***
// Purpose: Analog side model: pin levels, temperature sensor, comparator.
// Assumes: Levels are ideal 12-bit codes; comparator has no offset.
// Notes: Level is held when sampling ends, as a real S/H would.
`timescale 1ns/1ps
module sasc_analog_model (
  input wire logic i_clock,
  input wire logic [107:0] i_levels,
  input wire logic [3:0] i_mux_sel,
  input wire logic i_sample,
  input wire logic [11:0] i_dac,
  output logic o_cmp
);
  logic [11:0] held_q;
  // ==========================================================================
  // Sample and hold
  // fixed pins and sensor
  always_ff @(posedge i_clock) begin
    if (i_sample) begin
      held_q <= i_levels[i_mux_sel*12 +: 12];
    end
  end
  assign o_cmp = (held_q >= i_dac);
endmodule : sasc_analog_model

// *** verification/test_sar_adc_sequencer_control.sv ***
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Inputs change at the falling edge; stream sink mostly ready.
// Notes: Expected codes are the levels the bench gives the analog model.
`timescale 1ns/1ps
module test_sar_adc_sequencer_control import sasc_pkg::*; ;
  localparam int DIV = 2;
  logic i_clock, i_resetn, i_enable, i_power_ok, i_scan_mode, i_fw_start, i_range_clr;
  logic i_scan_done_clr, i_cmp, i_st_en, i_st_ready, o_st_valid, o_temp_sel, o_sample;
  logic o_ext_ref_en, o_available, o_busy, o_range_irq, o_range_low, o_range_high, o_scan_done;
  logic [7:0] i_chan_en, i_temp_sample_time;
  logic [63:0] i_sample_time;
  logic [3:0] i_fw_chan, o_st_chan, o_mux_sel;
  logic [1:0] i_ref_sel, o_ref_sel;
  logic [11:0] i_low_limit, i_high_limit, o_st_data, o_dac;
  logic [8:0] i_buf_clr, o_buf_new;
  logic [107:0] o_results, levels;
  int fail_count, check_count, cycles, samp_n, busy_n, n;
  logic [3:0] fw_list [5] = '{4'h5, 4'h3, 4'h2, 4'h1, TEMP_CH};
  sasc_sar_sequencer #(.CONV_DIV(DIV)) dut_u (.i_clock, .i_resetn, .i_enable, .i_power_ok,
    .i_scan_mode, .i_chan_en, .i_sample_time, .i_temp_sample_time, .i_fw_start, .i_fw_chan,
    .i_ref_sel, .i_low_limit, .i_high_limit, .i_range_clr, .i_scan_done_clr, .i_buf_clr,
    .i_cmp, .i_st_en, .i_st_ready, .o_st_valid, .o_st_chan, .o_st_data, .o_mux_sel,
    .o_temp_sel, .o_sample, .o_dac, .o_ref_sel, .o_ext_ref_en, .o_available, .o_busy,
    .o_results, .o_buf_new, .o_range_irq, .o_range_low, .o_range_high, .o_scan_done);
  sasc_analog_model model_u (.i_clock(i_clock), .i_levels(levels), .i_mux_sel(o_mux_sel),
    .i_sample(o_sample), .i_dac(o_dac), .o_cmp(i_cmp));
  // ==========================================================================
  // Clock, counters and closing
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // Counted off the falling edge so combinational outputs have settled
  always @(negedge i_clock) begin
    cycles++;
    samp_n += int'(o_sample === 1'b1);
    busy_n += int'(o_busy === 1'b1);
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  // ==========================================================================
  // Access tasks
  function automatic int exp_samp(input logic [3:0] ch);
    int st;
    st = (ch == TEMP_CH) ? int'(i_temp_sample_time) : int'(i_sample_time[ch*8 +: 8]);
    return DIV * ((st < SAMPLE_MIN_CLKS) ? SAMPLE_MIN_CLKS : st);
  endfunction : exp_samp
  task automatic wait_flag(input int idx);
    n = 0;
    while (((idx < 9) ? o_buf_new[idx] : o_scan_done) !== 1'b1 && n < 600) begin
      @(negedge i_clock);
      n++;
    end
  endtask : wait_flag
  task automatic fw_conv(input logic [3:0] ch);
    logic [11:0] lvl;
    lvl = levels[ch*12 +: 12];
    i_buf_clr = 9'h001 << ch;
    i_range_clr = 1'b1;
    @(negedge i_clock);
    i_buf_clr = 9'h000;
    i_range_clr = 1'b0;
    i_fw_chan = ch;
    i_fw_start = 1'b1;
    samp_n = 0;
    busy_n = 0;
    @(negedge i_clock);
    i_fw_start = 1'b0;
    wait_flag(ch);
    check_bit(o_buf_new[ch], 1'b1);
    check_val(o_results[ch*12 +: 12], lvl);
    check_val(o_dac, lvl);
    check_val({8'h00, o_mux_sel}, {8'h00, ch});
    check_bit(o_temp_sel, ch == TEMP_CH);
    check_val(12'(samp_n), 12'(exp_samp(ch)));
    check_bit(busy_n >= DIV * CONV_MIN_CLKS, 1'b1);
    check_bit(o_range_high, lvl > i_high_limit);
    check_bit(o_range_low, lvl < i_low_limit);
    check_bit(o_range_irq, lvl > i_high_limit || lvl < i_low_limit);
  endtask : fw_conv
  // ==========================================================================
  // Main sequence
  initial begin
    levels = {12'h5A1, 12'h3C0, 12'hD2E, 12'hF00, 12'h801, 12'hA5C, 12'h050, 12'h1FF, 12'h6B7};
    i_sample_time = {8'h0E, 8'h0A, 8'h08, 8'h07, 8'h0C, 8'h09, 8'h05, 8'h0B};
    {i_resetn, i_scan_mode, i_fw_start, i_range_clr, i_scan_done_clr} = 5'h00;
    {i_enable, i_power_ok, i_st_en, i_st_ready} = 4'hF;
    i_chan_en = 8'h00;
    i_temp_sample_time = 8'h03;
    i_fw_chan = 4'h0;
    i_ref_sel = 2'h0;
    i_low_limit = 12'h1FF;
    i_high_limit = 12'hE00;
    i_buf_clr = 9'h000;
    {fail_count, check_count, cycles} = 0;
    repeat (4) @(negedge i_clock);
    check_val(o_results[11:0], 12'h000);
    check_bit(o_range_irq | o_scan_done | o_busy, 1'b0);
    i_resetn = 1'b1;
    for (int r = 0; r < 4; r++) begin
      i_ref_sel = 2'(r);
      @(negedge i_clock);
      check_val({10'h000, o_ref_sel}, 12'(r));
      check_bit(o_ext_ref_en, r == 3);
    end
    // High, cleared, low, limit itself, then the sensor with a short window
    foreach (fw_list[i]) begin
      fw_conv(fw_list[i]);
    end
    // Scan with the sink stalled: the FIFO level must hold off starts and leave the engine idle
    i_buf_clr = 9'h1FF;
    i_scan_done_clr = 1'b1;
    i_st_ready = 1'b0;
    i_chan_en = 8'h52;
    i_scan_mode = 1'b1;
    @(negedge i_clock);
    i_buf_clr = 9'h000;
    i_scan_done_clr = 1'b0;
    repeat (400) @(negedge i_clock);
    check_bit(o_busy, 1'b0);
    check_bit(o_st_valid, 1'b1);
    check_val({8'h00, o_st_chan}, 12'h001);
    check_val(o_st_data, levels[23:12]);
    check_val({3'h0, o_buf_new}, 12'h000);
    i_st_ready = 1'b1;
    wait_flag(9);
    i_scan_done_clr = 1'b1;
    @(negedge i_clock);
    i_scan_done_clr = 1'b0;
    busy_n = 0;
    wait_flag(9);
    check_bit(o_scan_done, 1'b1);
    check_bit(n + 1 - busy_n <= 1, 1'b1);
    check_val({3'h0, o_buf_new}, 12'h052);
    check_val(o_results[23:12], levels[23:12]);
    check_val(o_results[59:48], levels[59:48]);
    check_val(o_results[83:72], levels[83:72]);
    i_power_ok = 1'b0;
    repeat (2) @(negedge i_clock);
    check_bit(o_available, 1'b0);
    check_bit(o_busy | o_sample, 1'b0);
    i_scan_mode = 1'b0;
    i_power_ok = 1'b1;
    repeat (2) @(negedge i_clock);
    check_bit(o_available, 1'b1);
    fw_conv(4'h0);
    stop_test();
  end
endmodule : test_sar_adc_sequencer_control
